// File: core/drm_pkg.sv
// constants and carrier types for the display row mapper
package drm_pkg;
	localparam int ROW_W = 7;
	localparam int RAM_ROWS = 128;
	localparam int LINES = 120;
	localparam int PIX_W = 128;
	localparam int BAND_STEP = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] TALL_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam int CTRL_BAND_LSB = 0;
	localparam int CTRL_TALL_EN = 2;
	localparam int CTRL_INV = 3;
	localparam int CTRL_SCROLL_LSB = 8;
	localparam int TALL_FIRST_LSB = 0;
	localparam int TALL_LAST_LSB = 8;
	localparam int STAT_LINE_LSB = 0;
	localparam int STAT_ROW_LSB = 8;
	localparam logic [ROW_W-1:0] LAST_LINE = 7'h77;
	localparam logic [ROW_W-1:0] ROW_RST = 7'h00;

	typedef struct packed {
		logic [1:0] fixed_band_select;
		logic [ROW_W-1:0] scroll_start_row;
		logic tall_rows_enable;
		logic [ROW_W-1:0] tall_rows_first;
		logic [ROW_W-1:0] tall_rows_last;
		logic invert;
	} drm_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} drm_apb_req_t;
endpackage : drm_pkg

// File: core/drm_row_map.sv
// maps a common line index onto a graphics ram row
`timescale 1ns/1ps
module drm_row_map (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [drm_pkg::ROW_W-1:0] line_i,
	input wire drm_pkg::drm_cfg_t cfg_i,
	output logic [drm_pkg::ROW_W-1:0] ram_row_o
);
	typedef struct packed {
		logic [drm_pkg::ROW_W-1:0] row;
	} drm_map_state_t;

	drm_map_state_t state_reg;
	drm_map_state_t state_next;

	// wrap past the last ram row to the first row after the band
	function automatic logic [8:0] drm_wrap(input logic [8:0] s,
		input logic [8:0] band);
		logic [8:0] r;
		r = s;
		if (r >= 9'(drm_pkg::RAM_ROWS)) begin
			r = 9'(r - 9'(drm_pkg::RAM_ROWS) + band);
		end
		return r;
	endfunction : drm_wrap

	// screen raster row after doubling, then ram row after band and scroll
	function automatic logic [drm_pkg::ROW_W-1:0] drm_map(
		input logic [drm_pkg::ROW_W-1:0] line, input drm_pkg::drm_cfg_t c);
		logic [8:0] v;
		logic [8:0] n;
		logic [8:0] first;
		logic [8:0] band;
		logic [8:0] s;
		first = 9'(c.tall_rows_first);
		n = 9'(c.tall_rows_last) - first + 9'h001;
		v = 9'(line);
		if (c.tall_rows_enable && v >= first) begin
			// region keyed to screen line, not ram row, so it stays put
			if (v < first + (n << 1)) begin
				v = first + ((v - first) >> 1);
			end else begin
				v = v - n;
			end
		end
		band = 9'(c.fixed_band_select) * 9'(drm_pkg::BAND_STEP);
		if (v < band) begin
			s = v;
		end else begin
			s = 9'(c.scroll_start_row) + (v - band);
			s = drm_wrap(drm_wrap(s, band), band);
		end
		return s[drm_pkg::ROW_W-1:0];
	endfunction : drm_map

	always_comb begin
		state_next = state_reg;
		if (ce_i) begin
			state_next.row = drm_map(line_i, cfg_i);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ram_row_o = state_reg.row;
endmodule : drm_row_map

// File: core/drm_invert.sv
// registered black-and-white reversal of one row of pixels
`timescale 1ns/1ps
module drm_invert #(
	parameter int PIX_W = drm_pkg::PIX_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic invert_i,
	input wire logic [PIX_W-1:0] pix_i,
	output logic [PIX_W-1:0] pix_o
);
	typedef struct packed {
		logic [PIX_W-1:0] pix;
	} drm_inv_state_t;

	drm_inv_state_t state_reg;
	drm_inv_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (ce_i) begin
			// applied after mapping so every row kind inverts alike
			state_next.pix = invert_i ? ~pix_i : pix_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pix_o = state_reg.pix;
endmodule : drm_invert

// File: core/drm_top.sv
// display row mapper: apb registers, line scan, row map and inversion
`timescale 1ns/1ps
module drm_top (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic line_adv_i,
	input wire logic [drm_pkg::PIX_W-1:0] pix_i,
	output logic [drm_pkg::ROW_W-1:0] row_driver_line_o,
	output logic [drm_pkg::ROW_W-1:0] graphics_ram_row_o,
	output logic [drm_pkg::PIX_W-1:0] seg_o
);
	typedef struct packed {
		drm_pkg::drm_cfg_t cfg;
		logic [drm_pkg::ROW_W-1:0] line;
		logic [31:0] rdata;
	} drm_top_state_t;

	drm_top_state_t state_reg;
	drm_top_state_t state_next;
	drm_pkg::drm_apb_req_t req;
	logic [drm_pkg::ROW_W-1:0] row_w;
	logic mapped;
	logic setup;
	logic access;

	function automatic logic drm_hit(input logic [7:0] a);
		return a == drm_pkg::CTRL_OFS || a == drm_pkg::TALL_OFS ||
			a == drm_pkg::STAT_OFS;
	endfunction : drm_hit

	assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
		paddr: paddr_i, pwdata: pwdata_i};
	assign mapped = drm_hit(req.paddr);
	assign setup = req.psel && !req.penable;
	assign access = req.psel && req.penable;
	// a frozen clock enable holds the bus in its access phase
	assign pready_o = ce_i;
	assign pslverr_o = access && !mapped;

	always_comb begin
		state_next = state_reg;
		if (ce_i) begin
			if (line_adv_i) begin
				if (state_reg.line == drm_pkg::LAST_LINE) begin
					state_next.line = drm_pkg::ROW_RST;
				end else begin
					state_next.line = 7'(state_reg.line + 7'h01);
				end
			end
			// read data built in setup so it stands registered in access
			if (setup && !req.pwrite) begin
				state_next.rdata = '0;
				unique case (req.paddr)
					drm_pkg::CTRL_OFS: begin
						state_next.rdata[drm_pkg::CTRL_BAND_LSB +: 2] =
							state_reg.cfg.fixed_band_select;
						state_next.rdata[drm_pkg::CTRL_TALL_EN] =
							state_reg.cfg.tall_rows_enable;
						state_next.rdata[drm_pkg::CTRL_INV] =
							state_reg.cfg.invert;
						state_next.rdata[drm_pkg::CTRL_SCROLL_LSB +:
							drm_pkg::ROW_W] = state_reg.cfg.scroll_start_row;
					end
					drm_pkg::TALL_OFS: begin
						state_next.rdata[drm_pkg::TALL_FIRST_LSB +:
							drm_pkg::ROW_W] = state_reg.cfg.tall_rows_first;
						state_next.rdata[drm_pkg::TALL_LAST_LSB +:
							drm_pkg::ROW_W] = state_reg.cfg.tall_rows_last;
					end
					drm_pkg::STAT_OFS: begin
						state_next.rdata[drm_pkg::STAT_LINE_LSB +:
							drm_pkg::ROW_W] = state_reg.line;
						state_next.rdata[drm_pkg::STAT_ROW_LSB +:
							drm_pkg::ROW_W] = row_w;
					end
					default: begin
						state_next.rdata = '0;
					end
				endcase
			end
			if (access && req.pwrite) begin
				unique case (req.paddr)
					drm_pkg::CTRL_OFS: begin
						state_next.cfg.fixed_band_select =
							req.pwdata[drm_pkg::CTRL_BAND_LSB +: 2];
						state_next.cfg.tall_rows_enable =
							req.pwdata[drm_pkg::CTRL_TALL_EN];
						state_next.cfg.invert =
							req.pwdata[drm_pkg::CTRL_INV];
						state_next.cfg.scroll_start_row =
							req.pwdata[drm_pkg::CTRL_SCROLL_LSB +:
							drm_pkg::ROW_W];
					end
					drm_pkg::TALL_OFS: begin
						// first above last is not trapped, software keeps it
						state_next.cfg.tall_rows_first =
							req.pwdata[drm_pkg::TALL_FIRST_LSB +:
							drm_pkg::ROW_W];
						state_next.cfg.tall_rows_last =
							req.pwdata[drm_pkg::TALL_LAST_LSB +:
							drm_pkg::ROW_W];
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	drm_row_map u_map (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.line_i(state_reg.line),
		.cfg_i(state_reg.cfg),
		.ram_row_o(row_w)
	);

	drm_invert #(
		.PIX_W(drm_pkg::PIX_W)
	) u_inv (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.invert_i(state_reg.cfg.invert),
		.pix_i(pix_i),
		.pix_o(seg_o)
	);

	assign prdata_o = state_reg.rdata;
	assign row_driver_line_o = state_reg.line;
	assign graphics_ram_row_o = row_w;
endmodule : drm_top

// File: tb/drm_props.sv
// assertions on the display row mapper ports
`timescale 1ns/1ps
module drm_props (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pslverr_o,
	input wire logic line_adv_i,
	input wire logic [127:0] pix_i,
	input wire logic [6:0] row_driver_line_o,
	input wire logic [6:0] graphics_ram_row_o,
	input wire logic [127:0] seg_o
);
	logic [14:0] c_reg;
	logic [6:0] t_reg;
	logic [6:0] sum;
	logic inv;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			c_reg <= '0;
			t_reg <= '0;
		end else if (psel_i && penable_i && pwrite_i && ce_i) begin
			if (paddr_i == drm_pkg::CTRL_OFS)
				c_reg <= pwdata_i[14:0];
			if (paddr_i == drm_pkg::TALL_OFS)
				t_reg <= pwdata_i[6:0];
		end
	end
	// seven-bit sum wraps past the last ram row by itself
	assign sum = row_driver_line_o + c_reg[14:8];
	assign inv = c_reg[3];
	sequence s_step;
		ce_i && line_adv_i ##1 ce_i;
	endsequence
	property p_step;
		ce_i && line_adv_i && row_driver_line_o != drm_pkg::LAST_LINE
		|=> row_driver_line_o == $past(row_driver_line_o) + 7'h01;
	endproperty
	a_step: assert property (p_step) else $error("line step");
	property p_wrap;
		ce_i && line_adv_i && row_driver_line_o == drm_pkg::LAST_LINE
		|=> row_driver_line_o == 7'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("line wrap");
	property p_hold;
		ce_i && !line_adv_i |=> $stable(row_driver_line_o);
	endproperty
	a_hold: assert property (p_hold) else $error("line moved");
	property p_fixed;
		s_step ##0 (!c_reg[2] && row_driver_line_o < {c_reg[1:0], 3'h0})
		|=> graphics_ram_row_o == $past(row_driver_line_o);
	endproperty
	a_fixed: assert property (p_fixed) else $error("band moved");
	property p_scroll;
		s_step ##0 (c_reg[2:0] == 3'h0) |=> graphics_ram_row_o == $past(sum);
	endproperty
	a_scroll: assert property (p_scroll) else $error("scroll row");
	property p_pair;
		s_step ##0 (c_reg == 15'h0004 && row_driver_line_o == t_reg + 7'h01)
		|=> graphics_ram_row_o == t_reg;
	endproperty
	a_pair: assert property (p_pair) else $error("tall pair");
	property p_seg;
		ce_i |=> seg_o == ($past(pix_i) ^ {128{$past(inv)}});
	endproperty
	a_seg: assert property (p_seg) else $error("segment data");
	property p_err;
		psel_i && penable_i && paddr_i > drm_pkg::STAT_OFS |-> pslverr_o;
	endproperty
	a_err: assert property (p_err) else $error("no slave error");
	property p_frozen;
		!ce_i |=> $stable(row_driver_line_o) && $stable(graphics_ram_row_o)
			&& $stable(seg_o);
	endproperty
	a_frozen: assert property (p_frozen) else $error("frozen state moved");
endmodule : drm_props
bind drm_top drm_props u_props (.ref_clk_i, .rst_i, .ce_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .line_adv_i,
	.pix_i, .row_driver_line_o, .graphics_ram_row_o, .seg_o);

// File: tb/drm_ram_model.sv
// graphics ram model answering the row that the mapper names
`timescale 1ns/1ps
module drm_ram_model (
	input wire logic [6:0] row_i,
	output logic [127:0] pix_o
);
	// a pattern of its own per row, so a wrong row shows
	assign pix_o = {16{1'h1, row_i}};
endmodule : drm_ram_model

// File: tb/test_display_row_mapper.sv
// bench for the display row mapper
`timescale 1ns/1ps
module test_display_row_mapper;
	typedef struct packed {
		logic [15:0] c, t;
		logic [6:0] l, r;
	} drm_vec_t;
	logic clk = 1'h0, rst = 1'h1, ce = 1'h1, sel = 1'h0, en = 1'h0;
	logic wr = 1'h0, adv = 1'h0, rdy, err, er;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = '0, rdata, rd;
	logic [127:0] pix, seg;
	logic [6:0] line, row, ln = 7'h00;
	int bad_count = 0, total_checks = 0;
	drm_vec_t v [11] = '{
		'{16'h7f00, 16'h0000, 7'h01, 7'h00},
		'{16'h7e01, 16'h0000, 7'h07, 7'h07},
		'{16'h7e01, 16'h0000, 7'h0a, 7'h08},
		'{16'h0802, 16'h0000, 7'h77, 7'h6f},
		'{16'h7f03, 16'h0000, 7'h19, 7'h18},
		'{16'h0004, 16'h2708, 7'h09, 7'h08},
		'{16'h0004, 16'h2708, 7'h47, 7'h27},
		'{16'h0004, 16'h0a08, 7'h0d, 7'h0a},
		'{16'h0504, 16'h0a08, 7'h09, 7'h0d},
		'{16'h0000, 16'h0a08, 7'h09, 7'h09},
		'{16'h0108, 16'h0000, 7'h05, 7'h06}
	};
	drm_top dut (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(sel),
		.penable_i(en), .pwrite_i(wr), .paddr_i(addr), .pwdata_i(wd),
		.prdata_o(rdata), .pready_o(rdy), .pslverr_o(err),
		.line_adv_i(adv), .pix_i(pix), .row_driver_line_o(line),
		.graphics_ram_row_o(row), .seg_o(seg));
	drm_ram_model ram (.row_i(row), .pix_o(pix));
	initial forever #25 clk = ~clk;
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [127:0] s, e, input string n);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
		int i;
		@(posedge clk);
		sel <= 1'h1;
		wr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		en <= 1'h1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rdy !== 1'h1 && i < 50);
		rd = rdata;
		er = err;
		sel <= 1'h0;
		en <= 1'h0;
		// a late but valid answer on the last try is not a timeout
		if (rdy !== 1'h1) begin
			bad_count++;
			complete_run();
		end
	endtask : apb
	// always at least one advance, so a target equal to the current line takes a whole frame
	task automatic go(input logic [6:0] t);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			adv <= 1'h1;
			@(posedge clk);
			adv <= 1'h0;
			ln = (ln == 7'h77) ? 7'h00 : ln + 7'h01;
			i++;
		end while (ln != t && i < 130);
		// a target line past the last one would never be reached
		if (ln != t) begin
			bad_count++;
			complete_run();
		end
		repeat (3) @(posedge clk);
	endtask : go
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		foreach (v[k]) begin
			apb(1'h1, drm_pkg::CTRL_OFS, {16'h0, v[k].c});
			apb(1'h1, drm_pkg::TALL_OFS, {16'h0, v[k].t});
			go(v[k].l);
			chk(line, v[k].l, "line");
			chk(row, v[k].r, "row");
			chk(seg, {16{1'h1, v[k].r}} ^ {128{v[k].c[3]}}, "seg");
		end
		apb(1'h0, drm_pkg::STAT_OFS, '0);
		chk(rd, {17'h0, v[10].r, 1'h0, v[10].l}, "status");
		apb(1'h0, drm_pkg::CTRL_OFS, '0);
		chk(rd, 32'h108, "ctrl");
		apb(1'h0, 8'h0c, '0);
		chk({er, rd}, 33'h1_0000_0000, "unmapped");
		// scroll start stepped by one, across the top of the ram
		for (int j = 126; j < 130; j++) begin
			apb(1'h1, drm_pkg::CTRL_OFS, {17'h0, 7'(j), 8'h00});
			repeat (2) @(posedge clk);
			chk(row, 7'(ln + 7'(j)), "step row");
		end
		// advance pulse while frozen must not move the line
		ce <= 1'h0;
		adv <= 1'h1;
		@(posedge clk);
		adv <= 1'h0;
		repeat (2) @(posedge clk);
		chk(line, ln, "frozen line");
		chk(row, 7'(ln + 7'h01), "frozen row");
		ce <= 1'h1;
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule : test_display_row_mapper
